// ===== reader_timers_map.vh
// Purpose: register offsets, field positions and reset values of the reader countdown timers
// Assumes: byte-wide registers on an 8-bit address
// Notes:   definitions only
`ifndef READER_TIMERS_MAP_VH
`define READER_TIMERS_MAP_VH

// register offsets
`define ADDR_RUN_CTRL   8'h0E
`define ADDR_T0_CNT_HI  8'h12
`define ADDR_T0_CNT_LO  8'h13
`define ADDR_T1_CTRL    8'h14
`define ADDR_T1_RLD_HI  8'h15
`define ADDR_T1_RLD_LO  8'h16
`define ADDR_T1_CNT_HI  8'h17
`define ADDR_T1_CNT_LO  8'h18
`define ADDR_T2_CTRL    8'h19
`define ADDR_FLAGS      8'h20

// timer control byte fields
`define CTRL_STOP_RX    7
`define CTRL_START_HI   5
`define CTRL_START_LO   4
`define CTRL_TRIM       5
`define CTRL_AUTO       3
`define CTRL_CLK_HI     1
`define CTRL_CLK_LO     0
`define CTRL_WMASK      8'hBB
`define CTRL_RESET      8'h00
`define RELOAD_RESET    16'h0000
`define COUNT_ZERO      16'h0000
`define COUNT_ONE       16'h0001

// start-mode codes
`define START_NONE      2'h0
`define START_TX_END    2'h1
`define START_TRIM      2'h2
`define START_TRIM_UF   2'h3

// clock-select codes
`define CLK_REF         2'h0
`define CLK_SUB         2'h1
`define CLK_UF_A        2'h2
`define CLK_UF_B        2'h3

// run control fields
`define RUN_T0          4
`define RUN_T1          5
`define RUN_T2          6
`define NOW_T0          0
`define NOW_T1          1
`define NOW_T2          2

// flags register fields
`define FLAG_T1         0
`define FLAG_T2         1

// receive bits counted before a stop-on-receive halt
`define RX_STOP_BITS    3'h4
`define RX_BITS_LAST    3'h3

`endif

// ===== countdown_timer.v
// Purpose: one 16-bit countdown timer core
// Assumes: start and stop are one-cycle pulses, never both at once
// Notes:   tick is a one-cycle count enable chosen by the parent
`default_nettype none
`include "reader_timers_map.vh"

module countdown_timer (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        tick,
    input  wire        startEv,
    input  wire        stopEv,
    input  wire        autoReload,
    input  wire        underflowOn,
    input  wire [15:0] reload,
    output reg  [15:0] count_r,
    output reg         running_r,
    output reg         underflow_r
);

////////////////////////////////////////////////////////////////////////////////

always @(posedge clk) begin
    if (sys_rst) begin
        count_r     <= `COUNT_ZERO;
        running_r   <= 1'b0;
        underflow_r <= 1'b0;
    end else begin
        underflow_r <= 1'b0;
        if (startEv) begin
            count_r   <= reload;
            running_r <= 1'b1;
        end else if (stopEv) begin
            running_r <= 1'b0;
        end else if (running_r && tick) begin
            if (count_r == `COUNT_ZERO) begin
                underflow_r <= underflowOn;
                if (autoReload) begin
                    count_r <= reload;
                end else begin
                    running_r <= 1'b0;
                end
            end else begin
                count_r <= count_r - `COUNT_ONE;
            end
        end
    end
end

endmodule
`default_nettype wire

// ===== reader_countdown_timers.v
// Purpose: Timer1 with control, reload and readback; Timer0 readback; Timer2 control
// Assumes: tick and transceiver strobes come from logic on clk; the trim input is a pin
// Notes:   Timer0 control and Timer2 reload arrive as ports from neighbouring registers
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
`include "reader_timers_map.vh"

// Behaviour
// - stop-on-receive set halts the timer after the first 4 received bits.
// - stop-on-receive is ignored when start mode selects oscillator trimming.
// - start mode 00 never auto-starts; 01 starts at end of transmission.
// - modes 10 and 11 trim the oscillator, starting and stopping on rising edges.
// - auto-restart set reloads the count each time zero is reached, except in start mode 10.
// - auto-restart clear counts down to zero and stops.
// - each Timer1 underflow sets the Timer1 underflow flag, except in start mode 10.
// - clock select picks reference, sub-carrier, Timer0 or Timer2 underflow.
// - a start event copies the 16-bit reload value into the counter.
// - reload writes leave a running count alone until the next start or auto-restart reload.
// - reload value held as high and low read/write bytes.
// - Timer0 and Timer1 counts read back as live high and low bytes.
// - Timer2 control uses the same layout and start codes.
// - Timer2 clock codes 10 and 11 pick Timer0 and Timer1 underflow.
// - each Timer2 underflow sets the Timer2 underflow flag, except in start mode 10.
// - a write changes a running bit only when its start-stop-now bit is written set.
module reader_countdown_timers (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [7:0]  addr,
    input  wire [7:0]  wrData,
    input  wire        wrStrobe,
    input  wire        rdStrobe,
    output reg  [7:0]  rdData_r,
    input  wire        tickRef,
    input  wire        tickSub,
    input  wire        txEnd,
    input  wire        rxStart,
    input  wire        rxBit,
    input  wire        lowFreqOscPin,
    input  wire [7:0]  timer0Control,
    input  wire [15:0] timer0Reload,
    input  wire [15:0] timer2Reload,
    output reg         timer1UnderflowFlag_r,
    output reg         timer2UnderflowFlag_r
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function selTick;
    input [1:0] sel;
    input       refTick;
    input       subTick;
    input       ufA;
    input       ufB;
    begin
        case (sel)
            `CLK_REF:  selTick = refTick;
            `CLK_SUB:  selTick = subTick;
            `CLK_UF_A: selTick = ufA;
            `CLK_UF_B: selTick = ufB;
            default:   selTick = 1'b0;
        endcase
    end
endfunction

function startEvent;
    input [7:0] ctrl;
    input       now;
    input       runReq;
    input       running;
    input       txDone;
    input       trimEdge;
    reg   [1:0] mode;
    begin
        mode = ctrl[`CTRL_START_HI:`CTRL_START_LO];
        startEvent = (now && runReq)
                   || (mode == `START_TX_END && txDone)
                   || (ctrl[`CTRL_TRIM] && trimEdge && !running);
    end
endfunction

function stopEvent;
    input [7:0] ctrl;
    input       now;
    input       runReq;
    input       running;
    input       rxFour;
    input       trimEdge;
    begin
        stopEvent = (now && !runReq)
                  || (ctrl[`CTRL_STOP_RX] && !ctrl[`CTRL_TRIM] && rxFour)
                  || (ctrl[`CTRL_TRIM] && trimEdge && running);
    end
endfunction

// trimming without underflow neither reloads nor flags
function reloadOn;
    input [7:0] ctrl;
    begin
        reloadOn = ctrl[`CTRL_AUTO]
                 && (ctrl[`CTRL_START_HI:`CTRL_START_LO] != `START_TRIM);
    end
endfunction

function flagOn;
    input [7:0] ctrl;
    begin
        flagOn = (ctrl[`CTRL_START_HI:`CTRL_START_LO] != `START_TRIM);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers and state

reg  [7:0]  timer1Control_r;
reg  [7:0]  timer1ReloadHigh_r;
reg  [7:0]  timer1ReloadLow_r;
reg  [7:0]  timer2Control_r;
reg         lfoMeta_r;
reg         lfoSync_r;
reg         lfoPrev_r;
reg  [2:0]  rxBits_r;
reg  [7:0]  rdMux;

// full-width copy so each reload byte takes its own half at reset
localparam [15:0] RELOAD_INIT = `RELOAD_RESET;

wire [15:0] count0;
wire [15:0] count1;
wire [15:0] count2;
wire        running0;
wire        running1;
wire        running2;
wire        underflow0;
wire        underflow1;
wire        underflow2;

wire        lfoRise;
wire        rxFour;
wire        runWrite;
wire        flagWrite;
wire [15:0] timer1Reload;
wire        tick0;
wire        tick1;
wire        tick2;
wire        start0;
wire        start1;
wire        start2;
wire        stop0;
wire        stop1;
wire        stop2;

////////////////////////////////////////////////////////////////////////////////
// trim input: the pin is asynchronous, so only the second and third stages feed the edge

always @(posedge clk) begin
    if (sys_rst) begin
        lfoMeta_r <= 1'b0;
        lfoSync_r <= 1'b0;
        lfoPrev_r <= 1'b0;
    end else begin
        lfoMeta_r <= lowFreqOscPin;
        lfoSync_r <= lfoMeta_r;
        lfoPrev_r <= lfoSync_r;
    end
end

assign lfoRise = lfoSync_r && !lfoPrev_r;

////////////////////////////////////////////////////////////////////////////////
// received-bit counter; saturates so the stop pulse fires once per frame

always @(posedge clk) begin
    if (sys_rst || rxStart) begin
        rxBits_r <= 3'h0;
    end else if (rxBit && rxBits_r != `RX_STOP_BITS) begin
        rxBits_r <= rxBits_r + 3'h1;
    end
end

assign rxFour = rxBit && !rxStart && (rxBits_r == `RX_BITS_LAST);

////////////////////////////////////////////////////////////////////////////////
// register writes

assign runWrite  = wrStrobe && (addr == `ADDR_RUN_CTRL);
assign flagWrite = wrStrobe && (addr == `ADDR_FLAGS);

always @(posedge clk) begin
    if (sys_rst) begin
        timer1Control_r    <= `CTRL_RESET;
        timer1ReloadHigh_r <= RELOAD_INIT[15:8];
        timer1ReloadLow_r  <= RELOAD_INIT[7:0];
        timer2Control_r    <= `CTRL_RESET;
    end else if (wrStrobe) begin
        case (addr)
            `ADDR_T1_CTRL:   timer1Control_r    <= wrData & `CTRL_WMASK;
            `ADDR_T1_RLD_HI: timer1ReloadHigh_r <= wrData;
            `ADDR_T1_RLD_LO: timer1ReloadLow_r  <= wrData;
            `ADDR_T2_CTRL:   timer2Control_r    <= wrData & `CTRL_WMASK;
            default: begin
            end
        endcase
    end
end

// only sampled on start or auto-reload at zero, so writes never touch a running count before then
assign timer1Reload = {timer1ReloadHigh_r, timer1ReloadLow_r};

////////////////////////////////////////////////////////////////////////////////
// count clocks; underflows are registered, so chained timers see them a cycle late

assign tick0 = selTick(timer0Control[`CTRL_CLK_HI:`CTRL_CLK_LO],
                       tickRef, tickSub, underflow2, underflow1);
assign tick1 = selTick(timer1Control_r[`CTRL_CLK_HI:`CTRL_CLK_LO],
                       tickRef, tickSub, underflow0, underflow2);
assign tick2 = selTick(timer2Control_r[`CTRL_CLK_HI:`CTRL_CLK_LO],
                       tickRef, tickSub, underflow0, underflow1);

////////////////////////////////////////////////////////////////////////////////
// start and stop events

assign start0 = startEvent(timer0Control, runWrite && wrData[`NOW_T0], wrData[`RUN_T0],
                           running0, txEnd, lfoRise);
assign stop0  = stopEvent(timer0Control, runWrite && wrData[`NOW_T0], wrData[`RUN_T0],
                          running0, rxFour, lfoRise);
assign start1 = startEvent(timer1Control_r, runWrite && wrData[`NOW_T1], wrData[`RUN_T1],
                           running1, txEnd, lfoRise);
assign stop1  = stopEvent(timer1Control_r, runWrite && wrData[`NOW_T1], wrData[`RUN_T1],
                          running1, rxFour, lfoRise);
assign start2 = startEvent(timer2Control_r, runWrite && wrData[`NOW_T2], wrData[`RUN_T2],
                           running2, txEnd, lfoRise);
assign stop2  = stopEvent(timer2Control_r, runWrite && wrData[`NOW_T2], wrData[`RUN_T2],
                          running2, rxFour, lfoRise);

////////////////////////////////////////////////////////////////////////////////
// timer cores

countdown_timer timer0 (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .tick        (tick0),
    .startEv     (start0),
    .stopEv      (stop0),
    .autoReload  (reloadOn(timer0Control)),
    .underflowOn (flagOn(timer0Control)),
    .reload      (timer0Reload),
    .count_r     (count0),
    .running_r   (running0),
    .underflow_r (underflow0)
);

countdown_timer timer1 (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .tick        (tick1),
    .startEv     (start1),
    .stopEv      (stop1),
    .autoReload  (reloadOn(timer1Control_r)),
    .underflowOn (flagOn(timer1Control_r)),
    .reload      (timer1Reload),
    .count_r     (count1),
    .running_r   (running1),
    .underflow_r (underflow1)
);

countdown_timer timer2 (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .tick        (tick2),
    .startEv     (start2),
    .stopEv      (stop2),
    .autoReload  (reloadOn(timer2Control_r)),
    .underflowOn (flagOn(timer2Control_r)),
    .reload      (timer2Reload),
    .count_r     (count2),
    .running_r   (running2),
    .underflow_r (underflow2)
);

////////////////////////////////////////////////////////////////////////////////
// underflow flags: a new underflow beats a clear in the same cycle

always @(posedge clk) begin
    if (sys_rst) begin
        timer1UnderflowFlag_r <= 1'b0;
        timer2UnderflowFlag_r <= 1'b0;
    end else begin
        timer1UnderflowFlag_r <= underflow1
            || (timer1UnderflowFlag_r && !(flagWrite && wrData[`FLAG_T1]));
        timer2UnderflowFlag_r <= underflow2
            || (timer2UnderflowFlag_r && !(flagWrite && wrData[`FLAG_T2]));
    end
end

////////////////////////////////////////////////////////////////////////////////
// readback; counts are live and not latched, so a read during reception may tear

always @* begin
    rdMux = 8'h00;
    case (addr)
        `ADDR_RUN_CTRL: begin
            rdMux[`RUN_T0] = running0;
            rdMux[`RUN_T1] = running1;
            rdMux[`RUN_T2] = running2;
        end
        `ADDR_T0_CNT_HI: rdMux = count0[15:8];
        `ADDR_T0_CNT_LO: rdMux = count0[7:0];
        `ADDR_T1_CTRL:   rdMux = timer1Control_r;
        `ADDR_T1_RLD_HI: rdMux = timer1ReloadHigh_r;
        `ADDR_T1_RLD_LO: rdMux = timer1ReloadLow_r;
        `ADDR_T1_CNT_HI: rdMux = count1[15:8];
        `ADDR_T1_CNT_LO: rdMux = count1[7:0];
        `ADDR_T2_CTRL:   rdMux = timer2Control_r;
        `ADDR_FLAGS: begin
            rdMux[`FLAG_T1] = timer1UnderflowFlag_r;
            rdMux[`FLAG_T2] = timer2UnderflowFlag_r;
        end
        default:         rdMux = 8'h00;
    endcase
end

always @(posedge clk) begin
    if (sys_rst) begin
        rdData_r <= 8'h00;
    end else if (rdStrobe) begin
        rdData_r <= rdMux;
    end else begin
        rdData_r <= 8'h00;
    end
end

endmodule
`default_nettype wire

// ===== reader_countdown_timers_sva.sv
// Purpose: port-level checks of the reader countdown timers
// Assumes: one clock, synchronous active-high reset
// Notes:   flag clearing is judged only well after the last tick
`default_nettype none
`include "reader_timers_map.vh"
module reader_countdown_timers_sva (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic       wrStrobe,
    input wire logic       rdStrobe,
    input wire logic [7:0] rdData_r,
    input wire logic       tickRef,
    input wire logic       tickSub,
    input wire logic       timer1UnderflowFlag_r,
    input wire logic       timer2UnderflowFlag_r
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////
    // chained underflows take a few hops, so wait out the tail
    logic [3:0] quietCnt_r;
    always_ff @(posedge clk) begin
        if (sys_rst || tickRef || tickSub)
            quietCnt_r <= 4'h0;
        else if (quietCnt_r != 4'hF)
            quietCnt_r <= quietCnt_r + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    a_idle_read_zero: assert property (!rdStrobe |=> rdData_r == 8'h00)
        else $error("read data not idle");
    a_reserved_bits_zero: assert property ((rdStrobe && (addr == `ADDR_T1_CTRL || addr == `ADDR_T2_CTRL))
        |=> (rdData_r[6] == 1'b0 && rdData_r[2] == 1'b0))
        else $error("reserved control bit reads one");
    a_ctrl_write_back: assert property ((wrStrobe && (addr == `ADDR_T1_CTRL || addr == `ADDR_T2_CTRL))
        ##1 (rdStrobe && addr == $past(addr)) |=> rdData_r == ($past(wrData, 2) & `CTRL_WMASK))
        else $error("control readback differs from write");
    a_reload_write_back: assert property ((wrStrobe && addr == `ADDR_T1_RLD_LO)
        ##1 (rdStrobe && addr == `ADDR_T1_RLD_LO) |=> rdData_r == $past(wrData, 2))
        else $error("reload readback differs from write");
    a_flag1_sticky: assert property (timer1UnderflowFlag_r
        && !(wrStrobe && addr == `ADDR_FLAGS && wrData[0]) |=> timer1UnderflowFlag_r)
        else $error("timer1 flag dropped without clear");
    a_flag2_sticky: assert property (timer2UnderflowFlag_r
        && !(wrStrobe && addr == `ADDR_FLAGS && wrData[1]) |=> timer2UnderflowFlag_r)
        else $error("timer2 flag dropped without clear");
    a_flag_read_match: assert property ((rdStrobe && addr == `ADDR_FLAGS)
        |=> rdData_r[1:0] == {$past(timer2UnderflowFlag_r), $past(timer1UnderflowFlag_r)})
        else $error("flag register differs from flag outputs");
    a_flag_clear_quiet: assert property (wrStrobe && addr == `ADDR_FLAGS
        && wrData[0] && quietCnt_r >= 4'h8 |=> !timer1UnderflowFlag_r)
        else $error("timer1 flag not cleared");
endmodule
bind reader_countdown_timers reader_countdown_timers_sva i_reader_countdown_timers_sva (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData_r(rdData_r), .tickRef(tickRef), .tickSub(tickSub),
    .timer1UnderflowFlag_r(timer1UnderflowFlag_r), .timer2UnderflowFlag_r(timer2UnderflowFlag_r));
`default_nettype wire

// ===== reader_countdown_timers_bench.sv
// Purpose: register-level tests of the reader countdown timers
// Assumes: 40 MHz clock, source ticks given as one-cycle enables
// Notes:   counters are never read during a reception
`default_nettype none
`include "reader_timers_map.vh"
module reader_countdown_timers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] TR = 5'h10, TS = 5'h08, TX = 5'h04, RS = 5'h02, RB = 5'h01, NO = 5'h00;
    localparam logic [7:0] RST_ADDRS [11] = '{8'h0E, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                                              8'h17, 8'h18, 8'h19, 8'h20, 8'h30};
    logic        clk, sys_rst, wrStrobe, rdStrobe, tickRef, tickSub, txEnd, rxStart, rxBit, lowFreqOscPin;
    logic [7:0]  addr, wrData, timer0Control;
    logic [15:0] timer0Reload;
    wire  [7:0]  rdData_r;
    wire         flag1, flag2;
    int          miscompares, checkCount, cycles;
    reader_countdown_timers i_reader_countdown_timers (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData_r(rdData_r), .tickRef(tickRef), .tickSub(tickSub), .txEnd(txEnd),
        .rxStart(rxStart), .rxBit(rxBit), .lowFreqOscPin(lowFreqOscPin), .timer0Control(timer0Control),
        .timer0Reload(timer0Reload), .timer2Reload(16'h0000),
        .timer1UnderflowFlag_r(flag1), .timer2UnderflowFlag_r(flag2));
    ////////////////////////////////////////
    task automatic tally_and_finish;
        if (miscompares == 0 && checkCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // strobe stays up until the next task's edge, so back-to-back access needs no gap
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        rdStrobe <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, e, m = 8'hFF);
        logic [7:0] d;
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        wrStrobe <= 1'b0;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 d = rdData_r & m;
        checkCount++;
        if (d !== (e & m)) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, d, e & m);
        end
    endtask
    // flag pins are compared off the edge, after rc has returned
    task automatic fc(input logic [1:0] e);
        checkCount++;
        if ({flag2, flag1} !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, {flag2, flag1}, e);
        end
    endtask
    task automatic ev(input logic [4:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            {wrStrobe, rdStrobe} <= 2'b00;
            {tickRef, tickSub, txEnd, rxStart, rxBit} <= v;
            @(posedge clk);
            {tickRef, tickSub, txEnd, rxStart, rxBit} <= NO;
        end
    endtask
    task automatic osc(input logic v);
        @(posedge clk);
        {wrStrobe, rdStrobe} <= 2'b00;
        lowFreqOscPin <= v;
        ev(NO, 3);
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        {addr, wrData, wrStrobe, rdStrobe, tickRef, tickSub, txEnd, rxStart, rxBit, lowFreqOscPin} = '0;
        timer0Control = 8'h08;
        timer0Reload = 16'h0102;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (RST_ADDRS[i])
            rc(RST_ADDRS[i], 8'h00);
        wr(8'h14, 8'hFF); rc(8'h14, 8'hBB);
        wr(8'h19, 8'hFF); rc(8'h19, 8'hBB);
        wr(8'h15, 8'hA5); rc(8'h15, 8'hA5);
        wr(8'h16, 8'h5A); rc(8'h16, 8'h5A);
        wr(8'h19, 8'h00); wr(8'h14, 8'h00); wr(8'h15, 8'h00); wr(8'h16, 8'h03);
        wr(8'h0E, 8'h22); rc(8'h18, 8'h03); rc(8'h17, 8'h00);
        wr(8'h16, 8'h10); rc(8'h18, 8'h03);
        ev(TR, 1); rc(8'h18, 8'h02);
        ev(TR, 3); ev(NO, 2); rc(8'h20, 8'h01, 8'h03); fc(2'h1);
        rc(8'h0E, 8'h00, 8'h70);
        wr(8'h20, 8'h03); ev(TR, 1); ev(NO, 2); rc(8'h20, 8'h00, 8'h03); fc(2'h0);
        wr(8'h16, 8'h02); wr(8'h14, 8'h08); wr(8'h0E, 8'h22);
        ev(TR, 3); ev(NO, 2); rc(8'h18, 8'h02); rc(8'h0E, 8'h20, 8'h70);
        wr(8'h0E, 8'h00); rc(8'h0E, 8'h20, 8'h70);
        wr(8'h0E, 8'h02); rc(8'h0E, 8'h00, 8'h70);
        wr(8'h14, 8'h00); ev(TX, 1); rc(8'h0E, 8'h00, 8'h70);
        wr(8'h14, 8'h10); ev(TX, 1); rc(8'h0E, 8'h20, 8'h70);
        ev(RS, 1); ev(RB, 4); rc(8'h0E, 8'h20, 8'h70);
        wr(8'h14, 8'h90); ev(RS, 1); ev(RB, 3); rc(8'h0E, 8'h20, 8'h70);
        ev(RB, 1); rc(8'h0E, 8'h00, 8'h70);
        for (int m = 2; m < 4; m++) begin
            wr(8'h14, 8'h80 | 8'(m << 4)); osc(1'b1); rc(8'h0E, 8'h20, 8'h70);
            ev(RS, 1); ev(RB, 4); rc(8'h0E, 8'h20, 8'h70);
            osc(1'b0); osc(1'b1); rc(8'h0E, 8'h00, 8'h70);
            osc(1'b0);
        end
        wr(8'h0E, 8'h11); rc(8'h12, 8'h01); rc(8'h13, 8'h02);
        @(posedge clk) timer0Reload <= 16'h0000;
        wr(8'h0E, 8'h11); wr(8'h19, 8'h08); wr(8'h0E, 8'h44);
        for (int c = 0; c < 4; c++) begin
            wr(8'h16, 8'h10); wr(8'h14, 8'(c)); wr(8'h0E, 8'h22);
            ev(TR, 1); ev(NO, 2); rc(8'h18, (c == 1) ? 8'h10 : 8'h0F);
            ev(TS, 1); ev(NO, 2); rc(8'h18, 8'h0F);
        end
        rc(8'h20, 8'h02, 8'h02);
        wr(8'h16, 8'h00); wr(8'h14, 8'h08); wr(8'h0E, 8'h22);
        for (int c = 1; c < 4; c++) begin
            wr(8'h19, 8'h08 | 8'(c)); ev(NO, 3); wr(8'h20, 8'h03);
            ev(TR, 1); ev(NO, 3); rc(8'h20, (c == 1) ? 8'h01 : 8'h03, 8'h03);
            fc((c == 1) ? 2'h1 : 2'h3);
        end
        rc(8'h0E, 8'h60, 8'h60);
        wr(8'h19, 8'h88); ev(RS, 1); ev(RB, 4); rc(8'h0E, 8'h20, 8'h60);
        tally_and_finish;
    end
endmodule
`default_nettype wire
